// [rtl/axr_regs.sv]
// ============================================================
module axr_regs
  import axr_pkg::*;
(
  // System
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Serial control port (link clock domain)
  input wire logic sclk_i,
  input wire logic scs_n_i,
  input wire logic sdata_i,
  // Mode inputs
  input wire logic ext_mode_i,
  input wire logic power_down_i,
  input wire logic output_edge_pin_i,
  input wire logic output_swing_pin_i,
  input wire logic double_rate_pin_n_i,
  // Decoded controls
  output logic double_rate_o,
  output logic rise_edge_o,
  output logic demux_o,
  output logic clk_zero_phase_o,
  output logic output_swing_select_o,
  output logic [7:0] offset1_mag_o,
  output logic offset1_neg_o,
  output logic [7:0] offset2_mag_o,
  output logic offset2_neg_o,
  output logic [8:0] gain1_o,
  output logic [8:0] gain2_o,
  output logic pattern_output_enable_o,
  output logic termination_trim_disable_o,
  output logic interleave_enable_o,
  output logic interleave_input_select_o,
  output logic low_rate_interleave_tuning_o,
  output logic recal_needed_o
);

  // ============================================================
  // Link side: shift register and frame counter on the serial clock
  logic [4:0] bit_cnt_reg;
  logic [30:0] shift_reg;
  logic [31:0] frame_reg;
  logic frame_tgl_reg;
  wire [31:0] shift_full = {shift_reg, sdata_i};

  // Shift in frames; a new frame may start at the 33rd clock
  always_ff @(posedge sclk_i or posedge scs_n_i) begin
    if (scs_n_i) begin
      bit_cnt_reg <= 5'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // Data path and completed-frame capture
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_reg <= '0;
      frame_reg <= '0;
      frame_tgl_reg <= 1'b0;
    end else if (!scs_n_i) begin
      shift_reg <= shift_full[30:0];
      if (bit_cnt_reg == AXR_FRAME_LAST) begin
        frame_reg <= shift_full;
        frame_tgl_reg <= ~frame_tgl_reg;
      end
    end
  end

  // ============================================================
  // Crossing: toggle synchroniser, frame word stable while toggle settles
  logic tgl_s1_reg;
  logic tgl_s2_reg;
  logic tgl_s3_reg;
  logic ext_s1_reg;
  logic ext_s2_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= frame_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
      ext_s1_reg <= ext_mode_i;
      ext_s2_reg <= ext_s1_reg;
    end
  end

  // Pin synchronisers
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
    end else begin
      pin_s1_reg <= {double_rate_pin_n_i, output_swing_pin_i, output_edge_pin_i};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Write decode: frame done, extended mode only
  wire frame_done = tgl_s2_reg ^ tgl_s3_reg;
  wire wr_en = frame_done & ext_s2_reg;
  wire [3:0] wr_addr = frame_reg[AXR_ADDR_MSB:AXR_ADDR_LSB];
  wire [15:0] wr_data = frame_reg[15:0];
  wire wr_cfg = wr_en && (wr_addr == AXR_ADDR_CFG);
  wire wr_ofs1 = wr_en && (wr_addr == AXR_ADDR_OFS1);
  wire wr_gain1 = wr_en && (wr_addr == AXR_ADDR_GAIN1);
  wire wr_samp = wr_en && (wr_addr == AXR_ADDR_SAMP);
  wire wr_ofs2 = wr_en && (wr_addr == AXR_ADDR_OFS2);
  wire wr_gain2 = wr_en && (wr_addr == AXR_ADDR_GAIN2);

  // ============================================================
  // Register bank; power-down does not touch it
  logic [15:0] cfg_reg;
  logic [15:0] ofs1_reg;
  logic [15:0] gain1_reg;
  logic [15:0] samp_reg;
  logic [15:0] ofs2_reg;
  logic [15:0] gain2_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_reg <= AXR_RST_CFG;
      ofs1_reg <= AXR_RST_OFS;
      gain1_reg <= AXR_RST_GAIN;
      samp_reg <= AXR_RST_SAMP;
      ofs2_reg <= AXR_RST_OFS;
      gain2_reg <= AXR_RST_GAIN;
    end else begin
      if (wr_cfg) begin
        cfg_reg <= wr_data;
      end
      if (wr_ofs1) begin
        ofs1_reg <= wr_data;
      end
      if (wr_gain1) begin
        gain1_reg <= wr_data;
      end
      if (wr_samp) begin
        samp_reg <= wr_data;
      end
      if (wr_ofs2) begin
        ofs2_reg <= wr_data;
      end
      if (wr_gain2) begin
        gain2_reg <= wr_data;
      end
    end
  end

  // ============================================================
  // Effective controls: registers in extended mode, pins otherwise
  wire ddr_n_eff = ext_s2_reg ? cfg_reg[AXR_CFG_DDR_N] : pin_s2_reg[2];
  wire swing_eff = ext_s2_reg ? cfg_reg[AXR_CFG_SWING] : pin_s2_reg[1];
  wire edge_eff = ext_s2_reg ? cfg_reg[AXR_CFG_EDGE] : pin_s2_reg[0];
  wire ddr_eff = ~ddr_n_eff;
  wire ext_on = ext_s2_reg;

  // Gain code in extended mode, nominal gain otherwise
  function automatic logic [8:0] gain_sel(input logic on, input logic [15:0] r);
    return on ? r[15:7] : 9'h100;
  endfunction
  // Offset magnitude in extended mode, zero otherwise
  function automatic logic [7:0] mag_sel(input logic on, input logic [15:0] r);
    return on ? r[15:8] : 8'h00;
  endfunction

  // Next values of the decoded controls
  wire double_rate_next = ddr_eff;
  wire rise_edge_next = ~ddr_eff & edge_eff;
  wire demux_next = ddr_eff & ~edge_eff;
  wire zero_phase_next = ddr_eff & edge_eff;
  wire swing_next = swing_eff;
  wire [7:0] ofs1_mag_next = mag_sel(ext_on, ofs1_reg);
  wire ofs1_neg_next = ext_on & ofs1_reg[AXR_OFS_SIGN];
  wire [7:0] ofs2_mag_next = mag_sel(ext_on, ofs2_reg);
  wire ofs2_neg_next = ext_on & ofs2_reg[AXR_OFS_SIGN];
  wire [8:0] gain1_next = gain_sel(ext_on, gain1_reg);
  wire [8:0] gain2_next = gain_sel(ext_on, gain2_reg);
  wire pattern_next = ext_on & samp_reg[AXR_SAMP_PAT];
  wire trim_next = ext_on & samp_reg[AXR_SAMP_TRIM];
  wire ilv_next = ext_on & samp_reg[AXR_SAMP_ILV];
  wire isel_next = ilv_next & samp_reg[AXR_SAMP_ISEL];
  wire lowr_next = ext_on & samp_reg[AXR_SAMP_LOWR];
  wire recal_next = 1'b0;

  // Output flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      double_rate_o <= 1'b1;
      rise_edge_o <= 1'b0;
      demux_o <= 1'b1;
      clk_zero_phase_o <= 1'b0;
      output_swing_select_o <= 1'b1;
      offset1_mag_o <= 8'h00;
      offset1_neg_o <= 1'b0;
      offset2_mag_o <= 8'h00;
      offset2_neg_o <= 1'b0;
      gain1_o <= 9'h100;
      gain2_o <= 9'h100;
      pattern_output_enable_o <= 1'b0;
      termination_trim_disable_o <= 1'b0;
      interleave_enable_o <= 1'b0;
      interleave_input_select_o <= 1'b0;
      low_rate_interleave_tuning_o <= 1'b0;
      recal_needed_o <= 1'b0;
    end else begin
      double_rate_o <= double_rate_next;
      rise_edge_o <= rise_edge_next;
      demux_o <= demux_next;
      clk_zero_phase_o <= zero_phase_next;
      output_swing_select_o <= swing_next;
      offset1_mag_o <= ofs1_mag_next;
      offset1_neg_o <= ofs1_neg_next;
      offset2_mag_o <= ofs2_mag_next;
      offset2_neg_o <= ofs2_neg_next;
      gain1_o <= gain1_next;
      gain2_o <= gain2_next;
      pattern_output_enable_o <= pattern_next;
      termination_trim_disable_o <= trim_next;
      interleave_enable_o <= ilv_next;
      interleave_input_select_o <= isel_next;
      low_rate_interleave_tuning_o <= lowr_next;
      recal_needed_o <= recal_next;
    end
  end

  // ============================================================
  // Assertions
  a_gain_no_recal: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_gain1 |-> ##[1:3] !recal_needed_o) else $error("gain write requested recalibration");
  a_ext_ignore: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (frame_done && !ext_s2_reg) |=> $stable(ofs1_reg) && $stable(samp_reg)) else $error("write taken outside ext mode");
  a_gain_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_gain1 ##1 ext_s2_reg |=> gain1_o == $past(wr_data[15:7], 2)) else $error("gain1 not loaded");
  a_ofs_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_ofs1 ##1 ext_s2_reg |=> offset1_neg_o == $past(wr_data[7], 2)) else $error("offset sign wrong");
  a_no_partial: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !frame_done |=> $stable(cfg_reg) && $stable(gain2_reg)) else $error("register changed without frame");
  a_pdown_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (power_down_i && !frame_done) |=> $stable(ofs2_reg)) else $error("register lost in power-down");
  a_ddr_phase: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_zero_phase_o |-> double_rate_o && !demux_o) else $error("zero phase outside DDR non-demux");
  a_sdr_edge: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rise_edge_o |-> !double_rate_o) else $error("edge select in DDR");
  a_demux_ddr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    demux_o |-> double_rate_o) else $error("demux outside DDR");
  a_isel_ilv: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    interleave_input_select_o |-> interleave_enable_o) else $error("input select without interleave");

  // Register loads one cycle after the write strobe
  // Config write lands
  a_cfg_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_cfg |=> cfg_reg == $past(wr_data))
    else $error("config write lost");
  // Sampling write lands
  a_samp_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_samp |=> samp_reg == $past(wr_data))
    else $error("sampling write lost");
  // Second offset write lands
  a_ofs2_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_ofs2 |=> ofs2_reg == $past(wr_data))
    else $error("second offset write lost");
  // Second gain write lands
  a_gain2_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_gain2 |=> gain2_reg == $past(wr_data))
    else $error("second gain write lost");
  // First offset magnitude reaches its output
  a_ofs1_mag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_ofs1 ##1 ext_s2_reg |=> offset1_mag_o == $past(wr_data[15:8], 2))
    else $error("offset magnitude wrong");
  // Second offset sign reaches its output
  a_ofs2_sign: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_ofs2 ##1 ext_s2_reg |=> offset2_neg_o == $past(wr_data[7], 2))
    else $error("second offset sign wrong");
  // Second gain code reaches its output
  a_gain2_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_gain2 ##1 ext_s2_reg |=> gain2_o == $past(wr_data[15:7], 2))
    else $error("second gain wrong");

  // Decoded controls follow the registers in extended mode
  // Rate select, low bit means double rate
  a_ddr_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ext_s2_reg |=> double_rate_o == !$past(cfg_reg[AXR_CFG_DDR_N]))
    else $error("rate select not followed");
  // Single rate never shows demux or zero phase
  a_sdr_no_demux: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !double_rate_o |-> !demux_o && !clk_zero_phase_o)
    else $error("demux in single rate");
  // Swing select
  a_swing_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ext_s2_reg |=> output_swing_select_o == $past(cfg_reg[AXR_CFG_SWING]))
    else $error("swing select not followed");
  // Edge select in single rate
  a_rise_sdr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ext_s2_reg && cfg_reg[AXR_CFG_DDR_N] |=> rise_edge_o == $past(cfg_reg[AXR_CFG_EDGE]))
    else $error("edge select not followed");
  // Demux select in double rate
  a_demux_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ext_s2_reg && !cfg_reg[AXR_CFG_DDR_N] |=> demux_o == !$past(cfg_reg[AXR_CFG_EDGE]))
    else $error("demux select not followed");
  // Zero phase in double rate non-demux
  a_zero_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ext_s2_reg && !cfg_reg[AXR_CFG_DDR_N] |=> clk_zero_phase_o == $past(cfg_reg[AXR_CFG_EDGE]))
    else $error("zero phase not followed");
  // Pattern output
  a_pat_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ext_s2_reg |=> pattern_output_enable_o == $past(samp_reg[AXR_SAMP_PAT]))
    else $error("pattern select not followed");
  // Trim disable
  a_trim_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ext_s2_reg |=> termination_trim_disable_o == $past(samp_reg[AXR_SAMP_TRIM]))
    else $error("trim disable not followed");
  // Interleave enable
  a_ilv_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ext_s2_reg |=> interleave_enable_o == $past(samp_reg[AXR_SAMP_ILV]))
    else $error("interleave enable not followed");
  // Input select while interleaved
  a_isel_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ext_s2_reg && samp_reg[AXR_SAMP_ILV] |=> interleave_input_select_o == $past(samp_reg[AXR_SAMP_ISEL]))
    else $error("input select not followed");
  // Low-rate tuning
  a_lowr_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ext_s2_reg |=> low_rate_interleave_tuning_o == $past(samp_reg[AXR_SAMP_LOWR]))
    else $error("low-rate tuning not followed");

  // Pin mode: registers have no effect
  // Offsets forced to zero
  a_pin_ofs: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ext_s2_reg |=> offset1_mag_o == 8'h00 && !offset1_neg_o && offset2_mag_o == 8'h00 && !offset2_neg_o)
    else $error("offset active in pin mode");
  // Gains forced to nominal
  a_pin_gain: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ext_s2_reg |=> gain1_o == 9'h100 && gain2_o == 9'h100)
    else $error("gain active in pin mode");
  // Rate taken from its pin
  a_pin_clk: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ext_s2_reg |=> double_rate_o == !$past(pin_s2_reg[2]))
    else $error("rate pin not followed");
  // Sampling options off
  a_pat_pins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ext_s2_reg |=> !pattern_output_enable_o && !interleave_enable_o)
    else $error("sampling option active in pin mode");

  // Frame handling
  // Counter wraps so the next frame starts at the 33rd clock
  a_frame_wrap: assert property (@(posedge sclk_i) disable iff (scs_n_i)
    bit_cnt_reg == AXR_FRAME_LAST |=> bit_cnt_reg == 5'h00)
    else $error("frame counter did not wrap");
  // One write strobe per completed frame
  a_done_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    frame_done |=> !frame_done)
    else $error("frame done held too long");
  c_cfg_write: cover property (@(posedge clk_i) disable iff (!rst_n_i) wr_cfg);
  c_samp_write: cover property (@(posedge clk_i) disable iff (!rst_n_i) wr_samp);
  c_ignored: cover property (@(posedge clk_i) disable iff (!rst_n_i) frame_done && !ext_s2_reg);
  c_pattern: cover property (@(posedge clk_i) disable iff (!rst_n_i) pattern_output_enable_o);
  c_back_to_back: cover property (@(posedge sclk_i) (bit_cnt_reg == AXR_FRAME_LAST && !scs_n_i) ##1 !scs_n_i);

endmodule

// [rtl/axr_pkg.sv]
// ============================================================
// Extended control register bank constants
package axr_pkg;
  // Register addresses
  localparam logic [3:0] AXR_ADDR_CFG = 4'h1;
  localparam logic [3:0] AXR_ADDR_OFS1 = 4'h2;
  localparam logic [3:0] AXR_ADDR_GAIN1 = 4'h3;
  localparam logic [3:0] AXR_ADDR_SAMP = 4'h9;
  localparam logic [3:0] AXR_ADDR_OFS2 = 4'ha;
  localparam logic [3:0] AXR_ADDR_GAIN2 = 4'hb;
  // Reset values
  localparam logic [15:0] AXR_RST_CFG = 16'hb2ff;
  localparam logic [15:0] AXR_RST_OFS = 16'h007f;
  localparam logic [15:0] AXR_RST_GAIN = 16'h807f;
  localparam logic [15:0] AXR_RST_SAMP = 16'h03ff;
  // Field positions
  localparam int AXR_CFG_DDR_N = 10;
  localparam int AXR_CFG_SWING = 9;
  localparam int AXR_CFG_EDGE = 8;
  localparam int AXR_SAMP_PAT = 15;
  localparam int AXR_SAMP_TRIM = 14;
  localparam int AXR_SAMP_ILV = 13;
  localparam int AXR_SAMP_ISEL = 12;
  localparam int AXR_SAMP_LOWR = 10;
  localparam int AXR_OFS_SIGN = 7;
  // Frame layout: 32 serial clocks, header bits then 4 address bits then data
  localparam int AXR_FRAME_BITS = 32;
  localparam logic [4:0] AXR_FRAME_LAST = 5'h1f;
  localparam int AXR_ADDR_MSB = 19;
  localparam int AXR_ADDR_LSB = 16;
endpackage

// [dv/axr_host_model.sv]
// ============================================================
// Host model driving the serial control port
module axr_host_model #(
  parameter logic [11:0] HDR = 12'h000 // Fixed header pattern, plain default
) (
  // Serial port
  output logic sclk_o,
  output logic scs_n_o,
  output logic sdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: clock stopped low, port deselected
  initial begin
    sclk_o = 1'b0;
    scs_n_o = 1'b1;
    sdata_o = 1'b0;
  end
  // Shift nbits of a frame MSB first at 15 ns per clock
  task automatic frame(input logic [3:0] a, input logic [15:0] d, input int nbits, input bit keep);
    logic [31:0] f;
    f = {HDR, a, d};
    scs_n_o = 1'b0;
    for (int i = 31; i > 31 - nbits; i--) begin
      sdata_o = f[i];
      #7.5 sclk_o = 1'b1;
      #7.5 sclk_o = 1'b0;
    end
    // Staying selected lets the next frame start on the 33rd clock
    if (!keep) begin
      #7.5 scs_n_o = 1'b1;
      sdata_o = ~sdata_o; // Released line never shows a stale bit
    end
  endtask
endmodule

// [dv/axr_regs_tb_top.sv]
// ============================================================
// Self-checking bench for the extended control register bank
module axr_regs_tb_top;
  import axr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_n_i, ext_mode_i, power_down_i, edge_pin, swing_pin, ddr_pin_n;
  logic sclk, scs_n, sdata;
  logic double_rate_o, rise_edge_o, demux_o, clk_zero_phase_o, output_swing_select_o;
  logic [7:0] offset1_mag_o, offset2_mag_o;
  logic offset1_neg_o, offset2_neg_o;
  logic [8:0] gain1_o, gain2_o;
  logic pattern_output_enable_o, termination_trim_disable_o, interleave_enable_o;
  logic interleave_input_select_o, low_rate_interleave_tuning_o, recal_needed_o;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Grouped views of the decoded controls
  wire logic [4:0] clk_grp = {double_rate_o, rise_edge_o, demux_o, clk_zero_phase_o, output_swing_select_o};
  wire logic [17:0] ofs_grp = {offset1_mag_o, offset1_neg_o, offset2_mag_o, offset2_neg_o};
  wire logic [17:0] gain_grp = {gain1_o, gain2_o};
  wire logic [5:0] samp_grp = {pattern_output_enable_o, termination_trim_disable_o, interleave_enable_o,
    interleave_input_select_o, low_rate_interleave_tuning_o, recal_needed_o};
  axr_regs axr_regs_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .scs_n_i(scs_n), .sdata_i(sdata),
    .ext_mode_i(ext_mode_i), .power_down_i(power_down_i), .output_edge_pin_i(edge_pin),
    .output_swing_pin_i(swing_pin), .double_rate_pin_n_i(ddr_pin_n), .double_rate_o(double_rate_o),
    .rise_edge_o(rise_edge_o), .demux_o(demux_o), .clk_zero_phase_o(clk_zero_phase_o),
    .output_swing_select_o(output_swing_select_o), .offset1_mag_o(offset1_mag_o),
    .offset1_neg_o(offset1_neg_o), .offset2_mag_o(offset2_mag_o), .offset2_neg_o(offset2_neg_o),
    .gain1_o(gain1_o), .gain2_o(gain2_o), .pattern_output_enable_o(pattern_output_enable_o),
    .termination_trim_disable_o(termination_trim_disable_o), .interleave_enable_o(interleave_enable_o),
    .interleave_input_select_o(interleave_input_select_o),
    .low_rate_interleave_tuning_o(low_rate_interleave_tuning_o), .recal_needed_o(recal_needed_o));
  axr_host_model axr_host_model_i (.sclk_o(sclk), .scs_n_o(scs_n), .sdata_o(sdata));
  // 50 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Let the crossing and register update settle
  task automatic settle();
    repeat (8) @(negedge clk_i);
  endtask
  task automatic tally_and_finish();
    $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_reset();
    chk(32'(clk_grp), 32'h15);
    chk(32'(ofs_grp), 32'h0);
    chk(32'(gain_grp), {14'h0, 9'h100, 9'h100});
    chk(32'(samp_grp), 32'h0);
    $display("test reset done");
  endtask
  task automatic t_out_cfg();
    axr_host_model_i.frame(AXR_ADDR_CFG, 16'hb5ff, 32, 1'b0);
    settle();
    chk(32'(clk_grp), 32'h08);
    axr_host_model_i.frame(AXR_ADDR_CFG, 16'hb3ff, 32, 1'b0);
    settle();
    chk(32'(clk_grp), 32'h13);
    $display("test output config done");
  endtask
  task automatic t_adjust();
    axr_host_model_i.frame(AXR_ADDR_OFS1, 16'hffff, 32, 1'b1);
    axr_host_model_i.frame(AXR_ADDR_OFS2, 16'h017f, 32, 1'b1);
    axr_host_model_i.frame(AXR_ADDR_GAIN1, 16'he07f, 32, 1'b1);
    axr_host_model_i.frame(AXR_ADDR_GAIN2, 16'h607f, 32, 1'b0);
    settle();
    chk(32'(ofs_grp), {14'h0, 8'hff, 1'b1, 8'h01, 1'b0});
    chk(32'(gain_grp), {14'h0, 9'h1c0, 9'h0c0});
    chk(32'(recal_needed_o), 32'h0);
    $display("test adjust done");
  endtask
  task automatic t_samp();
    axr_host_model_i.frame(AXR_ADDR_SAMP, 16'hf7ff, 32, 1'b0);
    settle();
    chk(32'(samp_grp), 32'h3e);
    axr_host_model_i.frame(AXR_ADDR_SAMP, 16'h93ff, 32, 1'b0);
    settle();
    chk(32'(samp_grp), 32'h20);
    $display("test sampling done");
  endtask
  task automatic t_partial_pd();
    power_down_i = 1'b1;
    axr_host_model_i.frame(AXR_ADDR_OFS1, 16'h0000, 31, 1'b0);
    settle();
    chk(32'(ofs_grp), {14'h0, 8'hff, 1'b1, 8'h01, 1'b0});
    power_down_i = 1'b0;
    $display("test partial frame done");
  endtask
  task automatic t_pins();
    ext_mode_i = 1'b0;
    axr_host_model_i.frame(AXR_ADDR_OFS1, 16'h007f, 32, 1'b0);
    settle();
    chk(32'(clk_grp), 32'h08);
    chk(32'(offset1_mag_o), 32'h0);
    ext_mode_i = 1'b1;
    settle();
    chk(32'(ofs_grp), {14'h0, 8'hff, 1'b1, 8'h01, 1'b0});
    $display("test pin mode done");
  endtask
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    ext_mode_i = 1'b1;
    power_down_i = 1'b0;
    edge_pin = 1'b1;
    swing_pin = 1'b0;
    ddr_pin_n = 1'b1;
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    settle();
    t_reset();
    t_out_cfg();
    t_adjust();
    t_samp();
    t_partial_pd();
    t_pins();
    tally_and_finish();
  end
endmodule
